/* File: src/gcz_gauge.sv */
// Gauge counters, clear maintenance, address decode and page erase commands
`timescale 1ns/1ps
`default_nettype none

module gcz_dur_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic active_i,
    input wire logic tick_i,
    input wire logic clear_i,
    output logic [15:0] count_o,
    output logic slow_o
);
    logic [7:0] sub_q;
    logic step;
    assign step = active_i && tick_i && (!slow_o || sub_q == gcz_pkg::SLOW_LAST);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sub_q <= 8'h00;
        end else if (clear_i) begin
            sub_q <= 8'h00;
        end else if (active_i && tick_i) begin
            sub_q <= sub_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= 16'h0000;
        end else if (clear_i) begin
            count_o <= 16'h0000;
        end else if (step) begin
            count_o <= count_o + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slow_o <= 1'b0;
        end else if (clear_i) begin
            slow_o <= 1'b0;
        end else if (step && count_o == 16'hffff) begin
            slow_o <= !slow_o;
        end
    end
endmodule : gcz_dur_timer

module gcz_gauge #(
    parameter int unsigned FAST_CYC = gcz_pkg::FAST_CYC,
    parameter int unsigned WAKE_CYC = gcz_pkg::WAKE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic selected_i,
    input wire logic frame_reset_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    output logic tx_valid_o,
    output logic [7:0] tx_byte_o,
    output logic erase_busy_o,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    input wire logic conv_pulse_i,
    input wire logic sense_discharge_i,
    input wire logic asleep_i,
    input wire logic [15:0] temp_i,
    output logic wake_o,
    output logic sleep_allow_o,
    output logic [2:0] woe_level_o,
    output logic status_out_o,
    output logic status_oe_o
);
    gcz_pkg::gcz_state_t state_q;
    logic [7:0] mem_q [0:255];
    logic [2:0] sync1_q, sync2_q;
    logic pulse_prev_q;
    logic [31:0] fast_cnt_q;
    logic fast_tick_q;
    logic [11:0] hour_cnt_q;
    logic [15:0] self_pre_q;
    logic self_pend_q;
    logic [31:0] wake_cnt_q;
    logic [15:0] dacc_q, cacc_q, self_q;
    logic [15:0] dtime, ctime;
    logic dslow, cslow;
    logic [4:0] clr_q;
    logic por_q, stat_q, sleep_allow_q;
    logic [2:0] woe_q;
    logic [7:0] lock_q;
    logic [7:0] crc_q;
    logic [15:0] code_q;
    logic [2:0] page_q;
    logic page_ok_q;
    logic [4:0] er_idx_q;
    logic [8:0] phys;
    logic is_flash, conv_edge, discharging, asleep, hour_tick, self_due, awake;
    logic [2:0] band;
    logic [15:0] self_last;
    logic [7:0] rd_val;

    // Converter pulse, polarity and sleep level cross in through two flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            pulse_prev_q <= 1'b0;
        end else begin
            sync1_q <= {asleep_i, sense_discharge_i, conv_pulse_i};
            sync2_q <= sync1_q;
            pulse_prev_q <= sync2_q[0];
        end
    end
    assign conv_edge = sync2_q[0] && !pulse_prev_q;
    assign discharging = sync2_q[1];
    assign asleep = sync2_q[2];

    // Fast tick at 4096 per hour, hour tick every 4096 fast ticks
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_cnt_q <= 32'h0;
            fast_tick_q <= 1'b0;
            hour_cnt_q <= 12'h000;
        end else begin
            fast_tick_q <= (fast_cnt_q == FAST_CYC - 1);
            fast_cnt_q <= (fast_cnt_q == FAST_CYC - 1) ? 32'h0 : fast_cnt_q + 32'h1;
            if (fast_tick_q) begin
                hour_cnt_q <= hour_cnt_q + 12'h001;
            end
        end
    end
    assign hour_tick = fast_tick_q && hour_cnt_q == gcz_pkg::HOUR_LAST;

    // Accumulators wrap freely; a clear beats a same-cycle count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dacc_q <= 16'h0000;
        end else if (clr_q[gcz_pkg::CLR_DACC]) begin
            dacc_q <= 16'h0000;
        end else if (conv_edge && discharging) begin
            dacc_q <= dacc_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cacc_q <= 16'h0000;
        end else if (clr_q[gcz_pkg::CLR_CACC]) begin
            cacc_q <= 16'h0000;
        end else if (conv_edge && !discharging) begin
            cacc_q <= cacc_q + 16'h0001;
        end
    end

    gcz_dur_timer u_dtime (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(discharging),
        .tick_i(fast_tick_q),
        .clear_i(clr_q[gcz_pkg::CLR_DTIME]),
        .count_o(dtime),
        .slow_o(dslow)
    );

    gcz_dur_timer u_ctime (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(!discharging),
        .tick_i(fast_tick_q),
        .clear_i(clr_q[gcz_pkg::CLR_CTIME]),
        .count_o(ctime),
        .slow_o(cslow)
    );

    // Temperature band picks the self-drain period
    always_comb begin
        band = 3'd0;
        for (int i = 0; i < 7; i++) begin
            if (temp_i >= gcz_pkg::TEMP_EDGES[i]) begin
                band = 3'(i + 1);
            end
        end
    end
    assign self_last = (gcz_pkg::SELF_SLOWEST >> band) - 16'h0001;
    assign self_due = fast_tick_q && self_pre_q >= self_last;
    assign awake = !asleep || wake_o;

    // Asleep, at most one due count is held pending until the hourly wake window
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            self_pre_q <= 16'h0000;
            self_pend_q <= 1'b0;
            self_q <= 16'h0000;
        end else begin
            if (fast_tick_q) begin
                self_pre_q <= self_due ? 16'h0000 : self_pre_q + 16'h0001;
            end
            if (clr_q[gcz_pkg::CLR_SELF]) begin
                self_q <= 16'h0000;
                self_pend_q <= 1'b0;
            end else if ((self_due || self_pend_q) && awake) begin
                self_q <= self_q + 16'h0001;
                self_pend_q <= 1'b0;
            end else if (self_due) begin
                self_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
            wake_cnt_q <= 32'h0;
        end else if (!asleep) begin
            wake_o <= 1'b0;
            wake_cnt_q <= 32'h0;
        end else if (hour_tick) begin
            wake_o <= 1'b1;
            wake_cnt_q <= 32'h0;
        end else if (wake_o) begin
            wake_o <= (wake_cnt_q != WAKE_CYC - 1);
            wake_cnt_q <= wake_cnt_q + 32'h1;
        end
    end

    // Address decode with aliasing of the upper space
    always_comb begin
        if (mem_addr_i <= gcz_pkg::DECODE_TOP) begin
            phys = mem_addr_i[8:0];
        end else begin
            phys = {mem_addr_i[7:0] < gcz_pkg::ALIAS_LOW, mem_addr_i[7:0]};
        end
    end
    assign is_flash = !phys[8] && phys[7:0] <= gcz_pkg::FLASH_TOP;

    always_comb begin
        case (phys)
            gcz_pkg::REG_LOCK: rd_val = lock_q;
            gcz_pkg::REG_TEMP_LO: rd_val = temp_i[7:0];
            gcz_pkg::REG_TEMP_HI: rd_val = temp_i[15:8];
            gcz_pkg::REG_CLEAR: rd_val = {1'b0, por_q, stat_q, clr_q};
            gcz_pkg::REG_SLEEP: rd_val = {1'b0, sleep_allow_q, cslow, dslow, woe_q, 1'b0};
            gcz_pkg::REG_CTIME_LO: rd_val = ctime[7:0];
            gcz_pkg::REG_CTIME_HI: rd_val = ctime[15:8];
            gcz_pkg::REG_DTIME_LO: rd_val = dtime[7:0];
            gcz_pkg::REG_DTIME_HI: rd_val = dtime[15:8];
            gcz_pkg::REG_SELF_LO: rd_val = self_q[7:0];
            gcz_pkg::REG_SELF_HI: rd_val = self_q[15:8];
            gcz_pkg::REG_CACC_LO: rd_val = cacc_q[7:0];
            gcz_pkg::REG_CACC_HI: rd_val = cacc_q[15:8];
            gcz_pkg::REG_DACC_LO: rd_val = dacc_q[7:0];
            gcz_pkg::REG_DACC_HI: rd_val = dacc_q[15:8];
            default: rd_val = phys[8] ? 8'h00 : mem_q[phys[7:0]];
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_rdata_o <= 8'h00;
        end else if (mem_rd_i) begin
            mem_rdata_o <= rd_val;
        end
    end

    // Control registers; clear bits live for one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_q <= 5'h00;
            por_q <= 1'b1;
            stat_q <= 1'b1;
            status_oe_o <= 1'b0;
        end else begin
            clr_q <= 5'h00;
            if (mem_wr_i && phys == gcz_pkg::REG_CLEAR) begin
                clr_q <= mem_wdata_i[4:0];
                por_q <= por_q & mem_wdata_i[gcz_pkg::CLR_POR];
                stat_q <= mem_wdata_i[gcz_pkg::CLR_STAT];
                status_oe_o <= !mem_wdata_i[gcz_pkg::CLR_STAT];
            end
        end
    end
    assign status_out_o = 1'b0;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_allow_q <= 1'b1;
            woe_q <= gcz_pkg::WOE_RESET;
            sleep_allow_o <= 1'b1;
            woe_level_o <= gcz_pkg::WOE_RESET;
            lock_q <= gcz_pkg::LOCK_RESET;
        end else begin
            if (mem_wr_i && phys == gcz_pkg::REG_SLEEP) begin
                sleep_allow_q <= mem_wdata_i[gcz_pkg::SW_SLEEP_ALLOW];
                sleep_allow_o <= mem_wdata_i[gcz_pkg::SW_SLEEP_ALLOW];
                woe_q <= mem_wdata_i[gcz_pkg::SW_WOE_LSB +: 3];
                woe_level_o <= mem_wdata_i[gcz_pkg::SW_WOE_LSB +: 3];
            end
            if (mem_wr_i && phys == gcz_pkg::REG_LOCK) begin
                lock_q <= lock_q & {1'b0, mem_wdata_i[6:0]};
            end
        end
    end

    // Storage: erase has the port while it runs
    always_ff @(posedge clk_i) begin
        if (state_q == gcz_pkg::GCZ_ERASE) begin
            mem_q[{page_q, er_idx_q}] <= gcz_pkg::ERASED;
        end else if (mem_wr_i && !phys[8]) begin
            if (!is_flash) begin
                mem_q[phys[7:0]] <= mem_wdata_i;
            end else if (lock_q[phys[7:5]]) begin
                mem_q[phys[7:0]] <= mem_q[phys[7:0]] & mem_wdata_i;
            end
        end
    end

    // Command engine
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= gcz_pkg::GCZ_IDLE;
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            crc_q <= 8'h00;
            code_q <= 16'h0000;
            page_q <= 3'h0;
            page_ok_q <= 1'b0;
            er_idx_q <= 5'h00;
            erase_busy_o <= 1'b0;
        end else begin
            tx_valid_o <= 1'b0;
            if (frame_reset_i || !selected_i) begin
                state_q <= gcz_pkg::GCZ_IDLE;
                erase_busy_o <= 1'b0;
            end else begin
                case (state_q)
                    gcz_pkg::GCZ_IDLE: begin
                        state_q <= gcz_pkg::GCZ_CMD;
                    end
                    gcz_pkg::GCZ_CMD: begin
                        if (rx_valid_i && rx_byte_i == gcz_pkg::CMD_PROFILE) begin
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= gcz_pkg::PROFILE_SIG;
                        end else if (rx_valid_i && rx_byte_i == gcz_pkg::CMD_ERASE) begin
                            crc_q <= gcz_pkg::gcz_crc(8'h00, rx_byte_i);
                            state_q <= gcz_pkg::GCZ_PAGE_LO;
                        end
                    end
                    gcz_pkg::GCZ_PAGE_LO: begin
                        if (rx_valid_i) begin
                            code_q[7:0] <= rx_byte_i;
                            crc_q <= gcz_pkg::gcz_crc(crc_q, rx_byte_i);
                            state_q <= gcz_pkg::GCZ_PAGE_HI;
                        end
                    end
                    gcz_pkg::GCZ_PAGE_HI: begin
                        if (rx_valid_i) begin
                            page_ok_q <= 1'b0;
                            for (int i = 0; i < gcz_pkg::NUM_PAGES; i++) begin
                                if ({rx_byte_i, code_q[7:0]} == gcz_pkg::PAGE_CODES[i]) begin
                                    page_q <= 3'(i);
                                    page_ok_q <= 1'b1;
                                end
                            end
                            code_q[15:8] <= rx_byte_i;
                            tx_valid_o <= 1'b1;
                            tx_byte_o <= gcz_pkg::gcz_crc(crc_q, rx_byte_i);
                            state_q <= gcz_pkg::GCZ_GO_WAIT;
                        end
                    end
                    gcz_pkg::GCZ_GO_WAIT: begin
                        if (rx_valid_i && rx_byte_i == gcz_pkg::CMD_GO && page_ok_q
                            && lock_q[page_q]) begin
                            er_idx_q <= 5'h00;
                            erase_busy_o <= 1'b1;
                            state_q <= gcz_pkg::GCZ_ERASE;
                        end else if (rx_valid_i) begin
                            state_q <= gcz_pkg::GCZ_CMD;
                        end
                    end
                    gcz_pkg::GCZ_ERASE: begin
                        er_idx_q <= er_idx_q + 5'h01;
                        if (er_idx_q == gcz_pkg::PAGE_LAST) begin
                            erase_busy_o <= 1'b0;
                            state_q <= gcz_pkg::GCZ_CMD;
                        end
                    end
                    default: state_q <= gcz_pkg::GCZ_IDLE;
                endcase
            end
        end
    end

    // Checks
    sequence erase_hdr_s;
        state_q == gcz_pkg::GCZ_PAGE_HI && rx_valid_i && selected_i && !frame_reset_i;
    endsequence
    sequence go_ok_s;
        state_q == gcz_pkg::GCZ_GO_WAIT && rx_valid_i && rx_byte_i == gcz_pkg::CMD_GO
            && page_ok_q && lock_q[page_q] && selected_i && !frame_reset_i;
    endsequence

    profile_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == gcz_pkg::GCZ_CMD && selected_i && !frame_reset_i && rx_valid_i
        && rx_byte_i == gcz_pkg::CMD_PROFILE |=> tx_valid_o && tx_byte_o == gcz_pkg::PROFILE_SIG)
        else $error("profile byte not answered");
    crc_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_hdr_s |=> tx_valid_o)
        else $error("erase CRC not sent after page code");
    select_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !selected_i |=> !tx_valid_o && state_q == gcz_pkg::GCZ_IDLE)
        else $error("activity while not selected");
    erase_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        go_ok_s ##1 (selected_i && !frame_reset_i) [*8] |-> erase_busy_o)
        else $error("erase did not run after go byte");
    erase_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == gcz_pkg::GCZ_GO_WAIT && rx_valid_i && !lock_q[page_q]
        |=> state_q != gcz_pkg::GCZ_ERASE)
        else $error("erase of locked page");
    clear_self_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_q[gcz_pkg::CLR_DACC] && !mem_wr_i |=> dacc_q == 16'h0000 && clr_q == 5'h00)
        else $error("clear bit did not act or self-clear");
    slow_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(dslow) && $changed(dtime) && dtime == 16'h0000
        && !$past(clr_q[gcz_pkg::CLR_DTIME])
        |-> dslow)
        else $error("discharge rollover missed slow flag");
    timer_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_q[gcz_pkg::CLR_DTIME] |=> dtime == 16'h0000 && !dslow)
        else $error("discharge timer clear incomplete");
    rsvd_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_rd_i && mem_addr_i == 16'h0100 |=> mem_rdata_o == 8'h00)
        else $error("reserved slot read not zero");
endmodule : gcz_gauge
`default_nettype wire

/* File: inc/gcz_pkg.sv */
// Constants, types and CRC helper for the gauge counter and erase block
package gcz_pkg;
    // Command bytes
    localparam logic [7:0] CMD_PROFILE = 8'h99;
    localparam logic [7:0] CMD_ERASE = 8'h40;
    localparam logic [7:0] CMD_GO = 8'h5a;
    // Profile signature, arbitrary value
    localparam logic [7:0] PROFILE_SIG = 8'h3c;
    // Page erase codes, page 0 in the low slot
    localparam logic [6:0][15:0] PAGE_CODES = {16'h00c0, 16'h00a0, 16'h0800, 16'h0060,
                                               16'h0040, 16'h0020, 16'h0000};
    localparam int unsigned NUM_PAGES = 7;
    localparam logic [7:0] FLASH_TOP = 8'hdf;
    localparam logic [4:0] PAGE_LAST = 5'h1f;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] ALIAS_LOW = 8'h20;
    // Address map
    localparam logic [15:0] DECODE_TOP = 16'h011f;
    localparam logic [8:0] REG_RSVD = 9'h100;
    localparam logic [8:0] REG_LOCK = 9'h101;
    localparam logic [8:0] REG_TEMP_LO = 9'h102;
    localparam logic [8:0] REG_TEMP_HI = 9'h103;
    localparam logic [8:0] REG_CLEAR = 9'h104;
    localparam logic [8:0] REG_SLEEP = 9'h105;
    localparam logic [8:0] REG_CTIME_LO = 9'h106;
    localparam logic [8:0] REG_CTIME_HI = 9'h107;
    localparam logic [8:0] REG_DTIME_LO = 9'h108;
    localparam logic [8:0] REG_DTIME_HI = 9'h109;
    localparam logic [8:0] REG_SELF_LO = 9'h10a;
    localparam logic [8:0] REG_SELF_HI = 9'h10b;
    localparam logic [8:0] REG_CACC_LO = 9'h10c;
    localparam logic [8:0] REG_CACC_HI = 9'h10d;
    localparam logic [8:0] REG_DACC_LO = 9'h10e;
    localparam logic [8:0] REG_DACC_HI = 9'h10f;
    // Clear register bits
    localparam int CLR_DACC = 0;
    localparam int CLR_CACC = 1;
    localparam int CLR_SELF = 2;
    localparam int CLR_DTIME = 3;
    localparam int CLR_CTIME = 4;
    localparam int CLR_STAT = 5;
    localparam int CLR_POR = 6;
    // Sleep and wake register bits
    localparam int SW_SLEEP_ALLOW = 6;
    localparam int SW_STC = 5;
    localparam int SW_STD = 4;
    localparam int SW_WOE_LSB = 1;
    localparam logic [7:0] LOCK_RESET = 8'h7f;
    localparam logic [2:0] WOE_RESET = 3'h7;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FAST_PERIOD_US = 878900;
    localparam int unsigned FAST_CYC = FAST_PERIOD_US * (1000 / CLK_PERIOD_NS);
    localparam int unsigned WAKE_S = 4;
    localparam int unsigned WAKE_CYC = WAKE_S * (1000000000 / CLK_PERIOD_NS);
    localparam logic [11:0] HOUR_LAST = 12'hfff;   // 4096 fast ticks per hour
    localparam logic [7:0] SLOW_LAST = 8'hff;      // 256 fast ticks per slow count
    localparam logic [15:0] SELF_SLOWEST = 16'h8000; // 8 hours in fast ticks
    // Band edges in quarter kelvin: 0, 10, 20, 30, 40, 50, 60 C
    localparam logic [6:0][15:0] TEMP_EDGES = {16'd1333, 16'd1293, 16'd1253, 16'd1213,
                                               16'd1173, 16'd1133, 16'd1093};

    typedef enum logic [5:0] {
        GCZ_IDLE = 6'b000001,
        GCZ_CMD = 6'b000010,
        GCZ_PAGE_LO = 6'b000100,
        GCZ_PAGE_HI = 6'b001000,
        GCZ_GO_WAIT = 6'b010000,
        GCZ_ERASE = 6'b100000
    } gcz_state_t;

    // CRC x^8+x^5+x^4+1, bits shifted in lsb first
    function automatic logic [7:0] gcz_crc(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ data[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        end
        return c;
    endfunction : gcz_crc
endpackage : gcz_pkg

/* File: test/gcz_host.sv */
// Host controller model driving command bytes
`timescale 1ns/1ps
`default_nettype none
module gcz_host (
    input wire logic clk_i,
    output logic selected_o,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    initial begin
        selected_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    task automatic pick;
        @(negedge clk_i);
        selected_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask : pick
    task automatic send(input logic [7:0] b);
        @(negedge clk_i);
        rx_valid_o = 1'b1;
        rx_byte_o = b;
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_byte_o = ~b;
    endtask : send
endmodule : gcz_host
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench for the gauge counter and erase block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mem_rd_i = 1'b0, mem_wr_i = 1'b0, conv_pulse_i = 1'b0, sense_discharge_i = 1'b1;
    logic frame_reset_i = 1'b0, asleep_i = 1'b0;
    logic [15:0] temp_i = 16'h0600;
    logic wake_o, status_out_o;
    logic [15:0] mem_addr_i = 16'h0000;
    logic [7:0] mem_wdata_i = 8'h00;
    logic selected_i, rx_valid_i, tx_valid_o, erase_busy_o, sleep_allow_o, status_oe_o;
    logic [7:0] rx_byte_i, tx_byte_o, mem_rdata_o;
    logic [2:0] woe_level_o;
    int num_errors = 0, samples_checked = 0;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    gcz_host host_u (.clk_i(clk_i), .selected_o(selected_i), .rx_valid_o(rx_valid_i),
        .rx_byte_o(rx_byte_i));
    gcz_gauge #(.FAST_CYC(4), .WAKE_CYC(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .selected_i(selected_i), .frame_reset_i(frame_reset_i), .rx_valid_i(rx_valid_i),
        .rx_byte_i(rx_byte_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
        .erase_busy_o(erase_busy_o), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
        .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
        .conv_pulse_i(conv_pulse_i), .sense_discharge_i(sense_discharge_i),
        .asleep_i(asleep_i), .temp_i(temp_i), .wake_o(wake_o), .sleep_allow_o(sleep_allow_o),
        .woe_level_o(woe_level_o), .status_out_o(status_out_o), .status_oe_o(status_oe_o));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {mem_wr_i, mem_addr_i, mem_wdata_i} = {1'b1, a, d};
        @(negedge clk_i);
        mem_wr_i = 1'b0;
    endtask : wr
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_i);
        {mem_rd_i, mem_addr_i} = {1'b1, a};
        @(negedge clk_i);
        mem_rd_i = 1'b0;
        chk("mem_rdata", mem_rdata_o, e);
    endtask : rc
    task automatic tx_wait(input logic [7:0] e);
        for (int i = 0; i < 3 && tx_valid_o !== 1'b1; i++) @(negedge clk_i);
        chk("tx_byte", (tx_valid_o === 1'b1) ? tx_byte_o : 8'hxx, e);
    endtask : tx_wait
    task automatic pulses(input logic dis, input int n);
        sense_discharge_i = dis;
        repeat (2 * n) begin
            repeat (3) @(negedge clk_i);
            conv_pulse_i = ~conv_pulse_i;
        end
        repeat (4) @(negedge clk_i);
    endtask : pulses
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        return c;
    endfunction : crc8
    task automatic close_out;
        if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        #50000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        chk("pins", {1'b0, wake_o, status_out_o, sleep_allow_o, woe_level_o, status_oe_o}, 8'h1e);
        rc(16'h0105, 8'h4e);
        host_u.pick();
        host_u.send(8'h99);
        tx_wait(gcz_pkg::PROFILE_SIG);
        host_u.send(8'h40);
        host_u.send(8'h00);
        host_u.send(8'h08);
        tx_wait(crc8(crc8(crc8(8'h00, 8'h40), 8'h00), 8'h08));
        host_u.send(8'h5a);
        chk("busy", {7'h00, erase_busy_o}, 8'h01);
        repeat (40) @(negedge clk_i);
        rc(16'h0085, 8'hff);
        rc(16'h0180, 8'hff);
        wr(16'h0101, 8'h7b);
        rc(16'h0101, 8'h7b);
        host_u.send(8'h40);
        host_u.send(8'h40);
        host_u.send(8'h00);
        tx_wait(crc8(crc8(crc8(8'h00, 8'h40), 8'h40), 8'h00));
        host_u.send(8'h5a);
        chk("busy", {7'h00, erase_busy_o}, 8'h00);
        host_u.send(8'h40);
        @(negedge clk_i) frame_reset_i = 1'b1;
        @(negedge clk_i) frame_reset_i = 1'b0;
        host_u.send(8'h99);
        tx_wait(gcz_pkg::PROFILE_SIG);
        wr(16'h00e5, 8'ha7);
        rc(16'h01e5, 8'ha7);
        wr(16'h0100, 8'h5c);
        rc(16'h0100, 8'h00);
        wr(16'h0104, 8'h3f);
        @(negedge clk_i);
        rc(16'h0104, 8'h20);
        pulses(1'b1, 3);
        rc(16'h010e, 8'h03);
        pulses(1'b0, 2);
        rc(16'h010c, 8'h02);
        rc(16'h010e, 8'h03);
        // Discharge timer is frozen while charging, so a cleared count stays zero
        wr(16'h0104, 8'h28);
        @(negedge clk_i);
        rc(16'h0108, 8'h00);
        sense_discharge_i = 1'b1;
        repeat (4) @(negedge clk_i);
        wr(16'h0104, 8'h30);
        @(negedge clk_i);
        rc(16'h0106, 8'h00);
        rc(16'h0105, 8'h4e);
        // One self-drain period spans 1024 cycles at the hottest band
        asleep_i = 1'b1;
        wr(16'h0104, 8'h24);
        repeat (1024) @(negedge clk_i);
        rc(16'h010a, 8'h00);
        asleep_i = 1'b0;
        wr(16'h0104, 8'h24);
        repeat (1024) @(negedge clk_i);
        rc(16'h010a, 8'h01);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
